// ==== vsf_pkg.sv ====
// Constants, types and functions shared by the slew and fault control block.
// Function
// - Suspend select high takes target from the two suspend code inputs.
// - Sample impedance code on source rise, power-up, or suspend fall; 4us.
// - A starting transition blanks power good so it cannot go low.
// - Power good returns after DAC reaches target plus one slew period.
// - DAC moves toward target by 25mV per slew period after a delay.
// - Delay before the first step lies between one and two slew periods.
// - Slew period per step is settable from about 2.6us to 26us.
// - Overvoltage indication sets the fault latch and shuts the converter down.
// - After overvoltage low-side drive stays high until control toggles or supply cycles.
// - Low-side drive is also high during supply lockout and in shutdown.
// - Overvoltage defeat input high or no-fault mode disables overvoltage protection.
// - Undervoltage below 70% latches PWM off until supply cycles or control toggles.
// - Undervoltage is ignored for the first 256 slew clocks after startup.
// - No-fault mode disables undervoltage protection.
// - Control at ground gives shutdown with low-side drive high.
// - Control open gives forced fixed-frequency PWM at every load.
// - Control at supply gives automatic PWM and pulse-skipping switchover.
// - A set fault latch holds fault mode until supply cycles or control low.
// - Control forced to 12V to 15V enters no-fault test mode.
// - No-fault mode disables protections, clears fault latch, runs as auto-skip.
package vsf_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ      = 40;
    localparam int SLEW_MIN_NS  = 2600;
    localparam int SLEW_MAX_NS  = 26000;
    localparam int SAMPLE_NS    = 4000;
    localparam int SLEW_MIN_CYC = (SLEW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SLEW_MAX_CYC = (SLEW_MAX_NS * CLK_MHZ) / 1000;
    localparam int SAMPLE_CYC   = (SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int PER_W        = 11;
    localparam logic [PER_W-1:0] SLEW_MIN = PER_W'(SLEW_MIN_CYC);
    localparam logic [PER_W-1:0] SLEW_MAX = PER_W'(SLEW_MAX_CYC);
    localparam logic [PER_W-1:0] SLEW_RESET = PER_W'(SLEW_MAX_CYC / 2);
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYC - 1);
    localparam logic [8:0] UV_BLANK_TICKS = 9'h100;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // ==========================================================
    // Levels of the four-level control, DAC scale
    localparam logic [1:0] SKIP_GND  = 2'h0;
    localparam logic [1:0] SKIP_OPEN = 2'h1;
    localparam logic [1:0] SKIP_VCC  = 2'h2;
    localparam logic [1:0] SKIP_HV   = 2'h3;
    localparam logic [5:0] LEVEL_RESET = 6'h00;
    localparam logic [5:0] LEVEL_FINE  = 6'h0f;
    localparam logic [5:0] LEVEL_KNEE  = 6'h10;
    localparam int SYNC_W = 24;

    typedef enum logic [3:0] {
        SL_IDLE   = 4'b0001,
        SL_WAIT   = 4'b0010,
        SL_STEP   = 4'b0100,
        SL_SETTLE = 4'b1000
    } vsf_slew_type;

    // Converts a five-bit voltage code to DAC level in 25mV units from 0.6V.
    // Codes above the knee move in 50mV strides, so they take two levels.
    function automatic logic [5:0] vsf_code_level(input logic [4:0] code);
        if (code[4]) begin
            vsf_code_level = LEVEL_FINE - {2'h0, code[3:0]};
        end else begin
            vsf_code_level = LEVEL_KNEE + {1'b0, LEVEL_FINE[3:0] - code[3:0], 1'b0};
        end
    endfunction

endpackage

// ==== vsf_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/1ps
module vsf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // System clock.
    input  wire logic         rst_n, // Asynchronous reset, active low.
    input  wire logic [W-1:0] d,     // Asynchronous levels.
    output logic      [W-1:0] q      // Synchronised levels.
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ==== vsf_slew_div.sv ====
// Divider that makes the one-cycle slew-rate clock enable.
`timescale 1ns/1ps
module vsf_slew_div
    import vsf_pkg::*;
(
    input  wire logic             clk,    // System clock.
    input  wire logic             rst_n,  // Asynchronous reset, active low.
    input  wire logic [PER_W-1:0] period, // Cycles per slew period.
    output logic                  tick    // One-cycle slew enable.
);
    logic [PER_W-1:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count >= period - PER_W'(1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + PER_W'(1);
            tick  <= 1'b0;
        end
    end
endmodule

// ==== vsf_ctrl.sv ====
// Top of the slew, power-good and fault supervision logic with APB access.
`timescale 1ns/1ps
module vsf_ctrl (
    input  wire logic        SYS_CLK,            // 40 MHz system clock.
    input  wire logic        RESET_N,            // Async reset, active low.
    input  wire logic        PSEL,               // APB select.
    input  wire logic        PENABLE,            // APB access phase.
    input  wire logic        PWRITE,             // APB direction.
    input  wire logic [7:0]  PADDR,              // APB byte address.
    input  wire logic [31:0] PWDATA,             // APB write data.
    output logic      [31:0] PRDATA,             // APB read data.
    output logic             PREADY,             // APB ready.
    output logic             PSLVERR,            // APB error, unmapped.
    input  wire logic        CODE_SOURCE_SELECT, // Logic or impedance code.
    input  wire logic        SUSPEND_SELECT,     // Suspend code select.
    input  wire logic [4:0]  VID_CODE_INPUTS,    // Logic-level code pins.
    input  wire logic [4:0]  VID_IMPEDANCE_HIGH, // Impedance test results.
    input  wire logic [3:0]  SUSPEND_CODE_INPUTS,// Two four-level pins.
    input  wire logic [1:0]  SKIP_SHUTDOWN_LEVEL,// Control pin level.
    input  wire logic        SUPPLY_UVLO,        // Supply lockout active.
    input  wire logic        OVERVOLTAGE_DETECT, // Output above 2V.
    input  wire logic        UNDERVOLTAGE_DETECT,// Output below 70%.
    input  wire logic        THERMAL_DETECT,     // Thermal shutdown trip.
    input  wire logic        OVERVOLTAGE_DEFEAT_INPUT, // Defeat, high.
    input  wire logic        POWER_GOOD_SENSE,   // Power-good comparator.
    output logic      [5:0]  DAC_LEVEL,          // DAC level, 25mV units.
    output logic             POWER_GOOD_OUTPUT,  // Blanked power good.
    output logic             IMPEDANCE_PROBE,    // Impedance test active.
    output logic             LOW_SIDE_GATE_DRIVE_HIGH, // Force DL high.
    output logic             PWM_ENABLE,         // Converter switching.
    output logic             SKIP_ENABLE,        // Pulse skipping allowed.
    output logic             SHUTDOWN            // Low-power shutdown.
);
    import vsf_pkg::*;

    // ==========================================================
    // Input synchronisation
    logic [SYNC_W-1:0] sync_q;
    logic        src_sel;
    logic        sus_sel;
    logic [4:0]  vid_code;
    logic [4:0]  imp_high;
    logic [3:0]  sus_code;
    logic [1:0]  skip_level;
    logic        uvlo;
    logic        ov_det;
    logic        uv_det;
    logic        th_det;
    logic        ov_defeat;
    logic        pg_sense;

    vsf_sync #(.W(SYNC_W)) u_sync (
        .clk   (SYS_CLK),
        .rst_n (RESET_N),
        .d     ({CODE_SOURCE_SELECT, SUSPEND_SELECT, VID_CODE_INPUTS,
                 VID_IMPEDANCE_HIGH, SUSPEND_CODE_INPUTS,
                 SKIP_SHUTDOWN_LEVEL, SUPPLY_UVLO, OVERVOLTAGE_DETECT,
                 UNDERVOLTAGE_DETECT, THERMAL_DETECT,
                 OVERVOLTAGE_DEFEAT_INPUT, POWER_GOOD_SENSE}),
        .q     (sync_q)
    );

    assign {src_sel, sus_sel, vid_code, imp_high, sus_code, skip_level,
            uvlo, ov_det, uv_det, th_det, ov_defeat, pg_sense} = sync_q;

    // ==========================================================
    // Slew-rate clock
    logic [PER_W-1:0] slew_period;
    logic             tick;

    vsf_slew_div u_div (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .period (slew_period),
        .tick   (tick)
    );

    // ==========================================================
    // Mode decode
    logic mode_sdn;
    logic mode_pwm;
    logic mode_skip;
    logic mode_nofault;

    assign mode_sdn     = (skip_level == SKIP_GND);
    assign mode_pwm     = (skip_level == SKIP_OPEN);
    assign mode_skip    = (skip_level == SKIP_VCC);
    assign mode_nofault = (skip_level == SKIP_HV);

    // ==========================================================
    // Impedance code sampling
    logic       src_sel_d;
    logic       sus_sel_d;
    logic       first;
    logic       sampling;
    logic [7:0] sample_cnt;
    logic [4:0] imp_code;
    logic       sample_start;

    // The synchroniser output is zero after reset, so a source select that was
    // already high at power-up is caught as a rise.
    assign sample_start = !sampling &&
        ((src_sel && !src_sel_d) ||
         (first && src_sel) ||
         (src_sel && sus_sel_d && !sus_sel));

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            src_sel_d <= 1'b0;
            sus_sel_d <= 1'b0;
            first     <= 1'b1;
        end else begin
            src_sel_d <= src_sel;
            sus_sel_d <= sus_sel;
            if (src_sel_d == src_sel) begin
                first <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sampling   <= 1'b0;
            sample_cnt <= '0;
            imp_code   <= '0;
        end else if (sample_start) begin
            sampling   <= 1'b1;
            sample_cnt <= '0;
        end else if (sampling) begin
            if (sample_cnt == SAMPLE_LAST) begin
                sampling <= 1'b0;
                imp_code <= imp_high;
            end else begin
                sample_cnt <= sample_cnt + 8'h01;
            end
        end
    end

    // ==========================================================
    // Target selection
    logic [5:0] target;

    always_comb begin
        if (sus_sel) begin
            target = LEVEL_FINE - {2'h0, sus_code};
        end else if (src_sel) begin
            target = vsf_code_level(imp_code);
        end else begin
            target = vsf_code_level(vid_code);
        end
    end

    // ==========================================================
    // Slew state machine
    vsf_slew_type state;
    logic [5:0]   dac;
    logic [5:0]   next_dac;

    always_comb begin
        if (dac < target) begin
            next_dac = dac + 6'h01;
        end else if (dac > target) begin
            next_dac = dac - 6'h01;
        end else begin
            next_dac = dac;
        end
    end

    // Stepping starts on the second tick after a change is seen, so the
    // wait before the first step is at most two slew periods.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= SL_IDLE;
            dac   <= LEVEL_RESET;
        end else begin
            case (state)
                SL_IDLE: begin
                    if (target != dac) begin
                        state <= SL_WAIT;
                    end
                end
                SL_WAIT: begin
                    if (tick) begin
                        state <= SL_STEP;
                    end
                end
                SL_STEP: begin
                    if (tick) begin
                        dac <= next_dac;
                        if (next_dac == target) begin
                            state <= SL_SETTLE;
                        end
                    end
                end
                SL_SETTLE: begin
                    if (target != dac) begin
                        state <= SL_STEP;
                    end else if (tick) begin
                        state <= SL_IDLE;
                    end
                end
                default: begin
                    state <= SL_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Fault latches and startup blanking
    logic       fault_ov;
    logic       fault_uv;
    logic       fault_th;
    logic       fault;
    logic [8:0] uv_blank_cnt;
    logic       uv_armed;

    assign fault    = fault_ov || fault_uv || fault_th;
    assign uv_armed = (uv_blank_cnt == UV_BLANK_TICKS);

    // Shutdown restarts the count, so every exit from it is a new startup.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            uv_blank_cnt <= '0;
        end else if (mode_sdn || uvlo) begin
            uv_blank_cnt <= '0;
        end else if (tick && !uv_armed) begin
            uv_blank_cnt <= uv_blank_cnt + 9'h001;
        end
    end

    // Shutdown and no-fault clear the latches and win over a new trip.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fault_ov <= 1'b0;
        end else if (mode_sdn || mode_nofault) begin
            fault_ov <= 1'b0;
        end else if (ov_det && !ov_defeat) begin
            fault_ov <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fault_uv <= 1'b0;
        end else if (mode_sdn || mode_nofault) begin
            fault_uv <= 1'b0;
        end else if (uv_det && uv_armed) begin
            fault_uv <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fault_th <= 1'b0;
        end else if (mode_sdn || mode_nofault) begin
            fault_th <= 1'b0;
        end else if (th_det) begin
            fault_th <= 1'b1;
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DAC_LEVEL                <= LEVEL_RESET;
            POWER_GOOD_OUTPUT        <= 1'b1;
            IMPEDANCE_PROBE          <= 1'b0;
            LOW_SIDE_GATE_DRIVE_HIGH <= 1'b1;
            PWM_ENABLE               <= 1'b0;
            SKIP_ENABLE              <= 1'b0;
            SHUTDOWN                 <= 1'b1;
        end else begin
            DAC_LEVEL       <= dac;
            IMPEDANCE_PROBE <= sampling;
            // Blanking holds the output high; it can only fall when idle.
            if (state != SL_IDLE || target != dac) begin
                POWER_GOOD_OUTPUT <= 1'b1;
            end else begin
                POWER_GOOD_OUTPUT <= pg_sense;
            end
            LOW_SIDE_GATE_DRIVE_HIGH <= mode_sdn || uvlo || fault;
            PWM_ENABLE  <= !mode_sdn && !uvlo && !fault;
            SKIP_ENABLE <= mode_skip || mode_nofault;
            SHUTDOWN    <= mode_sdn;
        end
    end

    // ==========================================================
    // APB slave: one wait state on every access
    logic access;
    logic mapped;
    logic [PER_W-1:0] wr_period;

    assign access = PSEL && PENABLE;
    assign mapped = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS);

    always_comb begin
        if (PWDATA[PER_W-1:0] < SLEW_MIN) begin
            wr_period = SLEW_MIN;
        end else if (PWDATA[PER_W-1:0] > SLEW_MAX) begin
            wr_period = SLEW_MAX;
        end else begin
            wr_period = PWDATA[PER_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else if (access && !PREADY) begin
            PREADY  <= 1'b1;
            PSLVERR <= !mapped;
            if (PWRITE || !mapped) begin
                PRDATA <= '0;
            end else if (PADDR == ADDR_CTRL) begin
                PRDATA <= {21'h0, slew_period};
            end else begin
                PRDATA <= {10'h0, sampling, uv_armed, mode_nofault,
                           mode_skip, mode_pwm, mode_sdn, fault_th,
                           fault_uv, fault_ov, state != SL_IDLE,
                           target, dac};
            end
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            slew_period <= SLEW_RESET;
        end else if (access && PREADY && PWRITE && PADDR == ADDR_CTRL) begin
            slew_period <= wr_period;
        end
    end

endmodule

// ==== vsf_ctrl_monitor.sv ====
// Port-level checker for the slew and fault control block.
`timescale 1ns/1ps
module vsf_ctrl_monitor
    import vsf_pkg::*;
(
    input wire logic       SYS_CLK,                  // Clock.
    input wire logic       RESET_N,                  // Reset.
    input wire logic       PREADY,                   // Ready.
    input wire logic [1:0] SKIP_SHUTDOWN_LEVEL,      // Mode.
    input wire logic       SUPPLY_UVLO,              // Lockout.
    input wire logic       OVERVOLTAGE_DETECT,       // Over.
    input wire logic       OVERVOLTAGE_DEFEAT_INPUT, // Defeat.
    input wire logic [5:0] DAC_LEVEL,                // DAC.
    input wire logic       POWER_GOOD_OUTPUT,        // Good.
    input wire logic       IMPEDANCE_PROBE,          // Probe.
    input wire logic       LOW_SIDE_GATE_DRIVE_HIGH, // Low side.
    input wire logic       PWM_ENABLE,               // Switching.
    input wire logic       SKIP_ENABLE,              // Skipping.
    input wire logic       SHUTDOWN                  // Shutdown.
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // ==========================================================
    // Helper counters
    // The idle counter starts saturated so power good may follow the
    // sense at once after reset, before any step has been taken.
    logic [7:0]  probe_cnt;
    logic [10:0] still_cnt;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) probe_cnt <= 8'h00;
        else if (IMPEDANCE_PROBE) probe_cnt <= probe_cnt + 8'h01;
        else probe_cnt <= 8'h00;
    end
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) still_cnt <= 11'h7ff;
        else if ($changed(DAC_LEVEL)) still_cnt <= 11'h000;
        else if (still_cnt != 11'h7ff) still_cnt <= still_cnt + 11'h001;
    end
    // ==========================================================
    // Properties
    property p_rdy; PREADY |=> !PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("ready held");
    property p_step; $changed(DAC_LEVEL) |->
        6'(DAC_LEVEL - $past(DAC_LEVEL)) inside {6'h01, 6'h3f}; endproperty
    a_step: assert property (p_step) else $error("dac jump");
    property p_space; $changed(DAC_LEVEL) |=> $stable(DAC_LEVEL)[*8];
    endproperty
    a_space: assert property (p_space) else $error("dac fast");
    property p_blank; $changed(DAC_LEVEL) |-> POWER_GOOD_OUTPUT[*8];
    endproperty
    a_blank: assert property (p_blank) else $error("good low");
    // At least 100 cycles, just under the shortest slew period, must pass after
    // the last step before power good may fall.
    property p_settle; !POWER_GOOD_OUTPUT |-> still_cnt >= 11'h064;
    endproperty
    a_settle: assert property (p_settle) else $error("good early");
    property p_probe; $fell(IMPEDANCE_PROBE) |-> probe_cnt == 8'ha0;
    endproperty
    a_probe: assert property (p_probe) else $error("probe length");
    property p_mode; $stable(SKIP_SHUTDOWN_LEVEL)[*8] |->
        SHUTDOWN == (SKIP_SHUTDOWN_LEVEL == SKIP_GND) &&
        SKIP_ENABLE == SKIP_SHUTDOWN_LEVEL[1]; endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_shut; SHUTDOWN |-> LOW_SIDE_GATE_DRIVE_HIGH && !PWM_ENABLE;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown drive");
    property p_ov; (OVERVOLTAGE_DETECT && !OVERVOLTAGE_DEFEAT_INPUT &&
        SKIP_SHUTDOWN_LEVEL == SKIP_VCC)[*8] |->
        LOW_SIDE_GATE_DRIVE_HIGH && !PWM_ENABLE; endproperty
    a_ov: assert property (p_ov) else $error("ov trip");
    property p_nf; (SKIP_SHUTDOWN_LEVEL == SKIP_HV && !SUPPLY_UVLO)[*8] |->
        PWM_ENABLE && SKIP_ENABLE; endproperty
    a_nf: assert property (p_nf) else $error("no fault");
endmodule

bind vsf_ctrl vsf_ctrl_monitor u_vsf_ctrl_monitor (.*);

// ==== vsf_cpu_model.sv ====
// Behavioural processor side that drives the code selection pins.
`timescale 1ns/1ps
module vsf_cpu_model (
    input  wire logic       clk,          // Clock.
    input  wire logic       probe,        // Impedance test active.
    input  wire logic [1:0] src,          // 0 logic, 1 impedance, 2 suspend.
    input  wire logic [4:0] code,         // Code to present.
    output logic            zsel = 1'b0,  // Source select.
    output logic            ssel = 1'b0,  // Suspend select.
    output logic      [4:0] vid  = 5'h1f, // Logic code pins.
    output logic      [4:0] imp  = 5'h00, // Impedance results.
    output logic      [3:0] suspend_select  = 4'h0   // Suspend code pins.
);
    // ==========================================================
    // Pins
    // Impedance results mean nothing outside the probe window, so they
    // show a pattern that changes every cycle there.
    logic [4:0] spin = 5'h00;
    always @(posedge clk) begin
        spin <= spin + 5'h0b;
        zsel <= (src == 2'h1);
        ssel <= (src == 2'h2);
        vid  <= (src == 2'h1) ? ~code : code;
        imp  <= probe ? code : spin;
        suspend_select  <= code[3:0];
    end
endmodule

// ==== test_vsf_ctrl.sv ====
// Self-checking bench for the slew and fault control block.
`timescale 1ns/1ps
module test_vsf_ctrl;
    import vsf_pkg::*;
    // ==========================================================
    // Signals
    logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, uvlo = 1'b0, ov = 1'b0;
    logic        uv = 1'b0, therm = 1'b0, defeat = 1'b0, sense = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, zsel, ssel, probe, low, pwm, skip, shut;
    logic        pg;
    logic [4:0]  vid, imp, code = 5'h1f, code2;
    logic [3:0]  suspend_select;
    logic [1:0]  src = 2'h0, level = 2'h0;
    logic [5:0]  dac, exp_dac;
    logic [32:0] exp_q[$];
    int          error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'hbc0b;

    always #12.5 sys_clk = ~sys_clk;

    vsf_ctrl u_vsf_ctrl (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CODE_SOURCE_SELECT(zsel),
        .SUSPEND_SELECT(ssel), .VID_CODE_INPUTS(vid), .VID_IMPEDANCE_HIGH(imp),
        .SUSPEND_CODE_INPUTS(suspend_select), .SKIP_SHUTDOWN_LEVEL(level),
        .SUPPLY_UVLO(uvlo), .OVERVOLTAGE_DETECT(ov), .UNDERVOLTAGE_DETECT(uv),
        .THERMAL_DETECT(therm), .OVERVOLTAGE_DEFEAT_INPUT(defeat),
        .POWER_GOOD_SENSE(sense), .DAC_LEVEL(dac), .POWER_GOOD_OUTPUT(pg),
        .IMPEDANCE_PROBE(probe), .LOW_SIDE_GATE_DRIVE_HIGH(low),
        .PWM_ENABLE(pwm), .SKIP_ENABLE(skip), .SHUTDOWN(shut)
    );
    vsf_cpu_model u_vsf_cpu_model (
        .clk(sys_clk), .probe(probe), .src(src), .code(code), .zsel(zsel),
        .ssel(ssel), .vid(vid), .imp(imp), .suspend_select(suspend_select)
    );

    // ==========================================================
    // Tasks
    task automatic chk(string what, logic [32:0] e, logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                       logic [32:0] e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait10();
        repeat (10) @(posedge sys_clk);
    endtask
    function automatic logic [5:0] lvl(logic [4:0] c);
        return c[4] ? 6'(31 - int'(c)) : 6'(46 - 2 * int'(c));
    endfunction

    // ==========================================================
    // Bus answers and run limit
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            report_and_stop();
        end
        if (pready === 1'b1)
            chk("apb", exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff,
                {pslverr, prdata});
    end

    // ==========================================================
    // Scenarios
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        apb(1'b1, ADDR_STATUS, 32'hffffffff, 33'h0);
        // The code pins read zero until synchronised, so a slew is pending.
        apb(1'b0, ADDR_STATUS, 32'h0, {1'b0, 32'h00011000});
        apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, 32'h00000208});
        apb(1'b1, ADDR_CTRL, 32'h00000032, 33'h0);
        apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, 32'h00000068});
        apb(1'b1, ADDR_CTRL, 32'h000007d0, 33'h0);
        apb(1'b1, 8'h08, 32'h00000068, {1'b1, 32'h0});
        apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, 32'h00000410});
        apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
        apb(1'b1, ADDR_CTRL, 32'h00000068, 33'h0);
        $display("test registers done");
        for (int lv = 0; lv < 4; lv++) begin
            level <= 2'(lv);
            wait10();
            chk("mode", {lv == 0, lv > 1, lv == 0, lv != 0},
                {shut, skip, low, pwm});
        end
        level <= SKIP_VCC;
        uvlo <= 1'b1;
        wait10();
        chk("lockout", 33'h2, {low, pwm});
        uvlo <= 1'b0;
        $display("test modes done");
        for (int s = 0; s < 3; s++) begin
            code2 = 5'($random(seed));
            code <= code2;
            src <= 2'(s);
            if (s == 1) exp_dac = lvl(code2);
            repeat (300) @(posedge sys_clk);
            code2 = 5'($random(seed));
            code <= code2;
            if (s == 0) exp_dac = lvl(code2);
            if (s == 2) exp_dac = 6'(15 - int'(code2[3:0]));
            for (int i = 0; i < 12000 && dac !== exp_dac; i++)
                @(posedge sys_clk);
            chk("dac", exp_dac, dac);
            repeat (250) @(posedge sys_clk);
            chk("good", 33'h0, pg);
        end
        $display("test slew done");
        ov <= 1'b1;
        defeat <= 1'b1;
        wait10();
        chk("defeat", 33'h1, {low, pwm});
        defeat <= 1'b0;
        wait10();
        chk("ov", 33'h2, {low, pwm});
        ov <= 1'b0;
        wait10();
        chk("ov held", 33'h2, {low, pwm});
        level <= SKIP_GND;
        wait10();
        level <= SKIP_VCC;
        wait10();
        chk("cleared", 33'h1, {low, pwm});
        therm <= 1'b1;
        wait10();
        chk("thermal", 33'h2, {low, pwm});
        level <= SKIP_HV;
        ov <= 1'b1;
        uv <= 1'b1;
        wait10();
        chk("no fault", 33'h3, {low, pwm, skip});
        level <= SKIP_VCC;
        therm <= 1'b0;
        ov <= 1'b0;
        wait10();
        chk("uv blank", 33'h1, {low, pwm});
        uv <= 1'b0;
        repeat (256 * 104 + 100) @(posedge sys_clk);
        uv <= 1'b1;
        wait10();
        chk("uv", 33'h2, {low, pwm});
        $display("test faults done");
        chk("queue", 33'h0, 33'(exp_q.size()));
        report_and_stop();
    end
endmodule
